// >>> verilog/fzv_voting.sv
// eight-zone fire voting, self-test scheduling and panel indicators
`timescale 1ns/1ps
module fzv_voting import fzv_pkg::*; #(
  parameter int MINUTE_CYCLES = MINUTE_CYC,
  parameter int BLINK_CYCLES  = BLINK_CYC,
  parameter int STROBE_CYCLES = STROBE_CYC
) (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic [5:0] cycle_sw,
  input  wire logic       separate_sw,
  input  wire logic [2:0] weight_sw,
  input  wire logic       nonlatch_sw,
  input  wire logic       slave_sw,
  input  wire logic       manual_test_sw,
  input  wire logic       test_mode,
  input  wire logic [7:0] zone_fire,
  input  wire logic       selftest_done,
  input  wire logic [7:0] selftest_cps,
  input  wire logic [7:0] bus_in,
  input  wire logic       strobe_in,
  output logic            fire_a,
  output logic            fire_b,
  output logic [7:0]      bus_out,
  output logic            optical_integrity_test,
  output logic [2:0]      selftest_zone,
  output logic [7:0]      selftest_fault,
  output logic            fault_led,
  output logic            inhibit_led,
  output logic [7:0]      zone_indicator,
  output logic [1:0]      voted_output_indicator,
  output logic            is_master
);

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // configuration capture
  logic       cfg_done;
  logic [5:0] cfg_cyc;
  logic       cfg_sep;
  logic [2:0] cfg_w;
  logic       cfg_nolatch;
  logic       cfg_slave;
  logic       cfg_manual;

  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_done    <= 1'b0;
      cfg_cyc     <= 6'h00;
      cfg_sep     <= 1'b0;
      cfg_w       <= 3'h0;
      cfg_nolatch <= 1'b0;
      cfg_slave   <= 1'b0;
      cfg_manual  <= 1'b0;
    end else if (ce && !cfg_done) begin
      cfg_done    <= 1'b1;
      cfg_cyc     <= cycle_sw;
      cfg_sep     <= separate_sw;
      cfg_w       <= weight_sw;
      cfg_nolatch <= nonlatch_sw;
      cfg_slave   <= slave_sw;
      cfg_manual  <= manual_test_sw;
    end
  end

  cfg_hold_a: assert property (cfg_done |=> $stable(cfg_sep) && $stable(cfg_w))
    else $error("configuration changed after capture");

  ////////////////////////////////////////////////////////////////////////////
  // test mode tracking
  logic test_q;
  logic clear;

  always_ff @(posedge clock) begin
    if (srst) begin
      test_q <= 1'b0;
    end else if (ce) begin
      test_q <= test_mode;
    end
  end

  assign clear = ce && test_q && !test_mode;

  ////////////////////////////////////////////////////////////////////////////
  // self-test period
  logic [8:0]  period;
  logic [30:0] pre_cnt;
  logic        min_tick;
  logic [8:0]  min_cnt;
  logic        cycle_tick;

  always_comb begin
    period = (cfg_cyc[5] ? W_4H : 9'h000) + (cfg_cyc[4] ? W_2H : 9'h000)
           + (cfg_cyc[3] ? W_1H : 9'h000) + (cfg_cyc[2] ? W_40M : 9'h000)
           + (cfg_cyc[1] ? W_20M : 9'h000) + (cfg_cyc[0] ? W_10M : 9'h000);
    if (cfg_cyc == 6'h00) begin
      period = W_ALL_OPEN;
    end
  end

  assign min_tick = (pre_cnt == 31'(MINUTE_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (srst) begin
      pre_cnt <= 31'h0000_0000;
    end else if (ce) begin
      pre_cnt <= min_tick ? 31'h0000_0000 : pre_cnt + 31'h0000_0001;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      min_cnt    <= 9'h000;
      cycle_tick <= 1'b0;
    end else if (ce) begin
      cycle_tick <= 1'b0;
      if (min_tick) begin
        if (min_cnt >= period - 9'h001) begin
          min_cnt    <= 9'h000;
          cycle_tick <= 1'b1;
        end else begin
          min_cnt <= min_cnt + 9'h001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // automatic self-test sequencing
  fzv_selftest_e st;
  logic [1:0]    fail [NZONES];
  logic          res_ok;

  assign res_ok = ce && selftest_done && st == ST_WAIT;

  always_ff @(posedge clock) begin
    if (srst) begin
      st                     <= ST_IDLE;
      optical_integrity_test <= 1'b0;
      selftest_zone          <= 3'h0;
    end else if (ce) begin
      optical_integrity_test <= 1'b0;
      case (st)
        ST_IDLE: begin
          if (cycle_tick && !cfg_manual && !test_mode) begin
            st            <= ST_REQ;
            selftest_zone <= 3'h0;
          end
        end
        ST_REQ: begin
          optical_integrity_test <= 1'b1;
          st                     <= ST_WAIT;
        end
        ST_WAIT: begin
          if (selftest_done) begin
            if (selftest_zone == LAST_ZONE) begin
              st <= ST_IDLE;
            end else begin
              st            <= ST_REQ;
              selftest_zone <= selftest_zone + 3'h1;
            end
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  generate
    for (genvar i = 0; i < NZONES; i++) begin : g_selftest
      always_ff @(posedge clock) begin
        if (srst) begin
          fail[i]           <= 2'h0;
          selftest_fault[i] <= 1'b0;
        end else if (res_ok && !test_mode && selftest_zone == 3'(i)) begin
          if (selftest_cps < TEST_MIN_CPS) begin
            if (fail[i] == LOW_RUN_LAST) begin
              selftest_fault[i] <= 1'b1;
            end else begin
              fail[i] <= fail[i] + 2'h1;
            end
          end else begin
            fail[i]           <= 2'h0;
            selftest_fault[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  selftest_third_a: assert property (
    res_ok && !test_mode && selftest_cps < TEST_MIN_CPS && fail[selftest_zone] == LOW_RUN_LAST
    |=> selftest_fault[$past(selftest_zone)])
    else $error("zone fault not flagged on third low self-test");

  ////////////////////////////////////////////////////////////////////////////
  // zone memory and voting
  logic       latch_eff;
  logic [7:0] seen;
  logic [7:0] src;
  logic [2:0] cnt_a;
  logic [2:0] cnt_b;
  logic [3:0] cnt_all;
  logic       vote_a;
  logic       vote_b;
  logic [1:0] vote_q;
  logic [7:0] up_cnt;
  logic [8:0] total_w;
  logic [7:0] total;
  logic [2:0] need;

  assign latch_eff = !cfg_nolatch || test_mode;

  always_ff @(posedge clock) begin
    if (srst) begin
      seen <= 8'h00;
    end else if (clear) begin
      seen <= zone_fire;
    end else if (ce) begin
      seen <= seen | zone_fire;
    end
  end

  assign src     = latch_eff ? (seen | zone_fire) : zone_fire;
  assign cnt_a   = 3'($countones(src[3:0]));
  assign cnt_b   = 3'($countones(src[7:4]));
  assign cnt_all = 4'($countones(src));
  assign total_w = {1'b0, up_cnt} + {5'h00, cnt_all};
  assign total   = total_w[8] ? 8'hFF : total_w[7:0];
  assign need    = (cfg_w == 3'h0) ? NEED_ONE : cfg_w;

  always_comb begin
    if (cfg_sep) begin
      vote_a = cnt_a >= (cfg_w[2] ? NEED_TWO : NEED_ONE);
      vote_b = cnt_b >= (cfg_w[1] ? NEED_TWO : NEED_ONE);
    end else begin
      vote_a = 1'b0;
      vote_b = total >= {5'h00, need};
    end
  end

  always_ff @(posedge clock) begin
    if (srst || clear) begin
      vote_q <= 2'b00;
    end else if (ce) begin
      if (latch_eff) begin
        vote_q <= vote_q | {vote_b, vote_a};
      end else begin
        vote_q <= {vote_b, vote_a};
      end
    end
  end

  latch_hold_a: assert property (ce && latch_eff && vote_q[1] && !clear |=> vote_q[1])
    else $error("latched vote dropped");
  nonlatch_a: assert property (ce && !latch_eff && !clear |=> vote_q[0] == $past(vote_a))
    else $error("non-latching vote does not follow live zones");
  sep_one_a: assert property (ce && cfg_sep && !cfg_w[2] && !clear
    && (zone_fire[3:0] != 4'h0) |=> vote_q[0])
    else $error("one of four did not fire output A");
  sep_two_a: assert property (ce && cfg_sep && cfg_w[1] && !clear
    && $countones(zone_fire[7:4]) >= 2 |=> vote_q[1])
    else $error("two of four did not fire output B");
  exit_clear_a: assert property (clear |=> vote_q == 2'b00 && seen == $past(zone_fire))
    else $error("state not cleared on return to normal");

  ////////////////////////////////////////////////////////////////////////////
  // chained data bus and strobe
  logic [15:0] stb_cnt;
  logic        stb_pend;

  always_ff @(posedge clock) begin
    if (srst) begin
      up_cnt   <= 8'h00;
      stb_cnt  <= 16'h0000;
      stb_pend <= 1'b0;
    end else if (ce) begin
      stb_pend <= 1'b0;
      if (!cfg_slave) begin
        up_cnt <= 8'h00;
        if (stb_cnt == 16'(STROBE_CYCLES - 1)) begin
          stb_cnt  <= 16'h0000;
          stb_pend <= 1'b1;
        end else begin
          stb_cnt <= stb_cnt + 16'h0001;
        end
      end else if (strobe_in) begin
        up_cnt   <= bus_in;
        stb_pend <= 1'b1;
      end
    end
  end

  master_zero_a: assert property (cfg_done && !cfg_slave |=> up_cnt == 8'h00)
    else $error("master counted upstream zones");

  ////////////////////////////////////////////////////////////////////////////
  // outputs and indicators
  logic [22:0] blink_cnt;
  logic        blink;

  always_ff @(posedge clock) begin
    if (srst) begin
      blink_cnt <= 23'h00_0000;
      blink     <= 1'b0;
    end else if (ce) begin
      if (blink_cnt == 23'(BLINK_CYCLES - 1)) begin
        blink_cnt <= 23'h00_0000;
        blink     <= !blink;
      end else begin
        blink_cnt <= blink_cnt + 23'h00_0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      fire_a    <= 1'b0;
      fire_b    <= 1'b0;
      bus_out   <= 8'h00;
      is_master <= 1'b1;
    end else if (ce) begin
      fire_a    <= !test_mode && (cfg_sep ? vote_q[0] : stb_pend);
      fire_b    <= !test_mode && vote_q[1];
      bus_out   <= (test_mode || cfg_sep) ? 8'h00 : total;
      is_master <= !cfg_slave;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      fault_led              <= 1'b0;
      inhibit_led            <= 1'b0;
      zone_indicator         <= 8'h00;
      voted_output_indicator <= 2'b00;
    end else if (ce) begin
      fault_led   <= test_mode;
      inhibit_led <= test_mode;
      voted_output_indicator <= test_mode ? vote_q : 2'b00;
      if (test_mode) begin
        zone_indicator <= (zone_fire & {8{blink}}) | (seen & ~zone_fire);
      end else begin
        zone_indicator <= 8'h00;
      end
    end
  end

  test_quiet_a: assert property (ce && test_mode |=> !fire_a && !fire_b && bus_out == 8'h00)
    else $error("external output active in test mode");
  test_leds_a: assert property (ce && test_mode |=> fault_led && inhibit_led)
    else $error("fault and inhibit indicators not lit in test mode");

endmodule

// >>> verilog/fzv_pkg.sv
// constants and types for the fire zone voting logic
package fzv_pkg;
  localparam int          CLOCK_HZ     = 20_000_000;
  localparam int          MINUTE_S     = 60;
  localparam int          MINUTE_CYC   = CLOCK_HZ * MINUTE_S;
  localparam int          BLINK_MS     = 250;
  localparam int          BLINK_CYC    = (CLOCK_HZ / 1000) * BLINK_MS;
  localparam int          STROBE_CYC   = 32;
  localparam logic [8:0]  W_4H         = 9'h0F0;
  localparam logic [8:0]  W_2H         = 9'h078;
  localparam logic [8:0]  W_1H         = 9'h03C;
  localparam logic [8:0]  W_40M        = 9'h028;
  localparam logic [8:0]  W_20M        = 9'h014;
  localparam logic [8:0]  W_10M        = 9'h00A;
  localparam logic [8:0]  W_ALL_OPEN   = 9'h001;
  localparam logic [7:0]  TEST_MIN_CPS = 8'h18;
  localparam logic [1:0]  LOW_RUN_LAST = 2'h2;
  localparam logic [2:0]  NEED_ONE     = 3'h1;
  localparam logic [2:0]  NEED_TWO     = 3'h2;
  localparam logic [2:0]  LAST_ZONE    = 3'h7;
  localparam int          NZONES       = 8;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} fzv_selftest_e;
endpackage

// >>> test/fzv_partner.sv
// detector model answering optical integrity self-test requests
`timescale 1ns/1ps
module fzv_partner #(
  parameter int REPLY_DELAY = 3
) (
  input  wire logic       clock,
  input  wire logic       optical_integrity_test,
  input  wire logic [2:0] selftest_zone,
  output logic            selftest_done,
  output logic [7:0]      selftest_cps,
  output int              pulse_count
);
  initial begin
    selftest_done = 1'b0;
    selftest_cps  = 8'h00;
    pulse_count   = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // zone 2 has a dirty window, all others read well
  task automatic reply(input logic [2:0] zone);
    repeat (REPLY_DELAY) @(posedge clock);
    #1;
    selftest_done = 1'b1;
    selftest_cps  = (zone == 3'h2) ? 8'h10 : 8'h30;
    @(posedge clock);
    #1;
    selftest_done = 1'b0;
    selftest_cps  = ~selftest_cps;
  endtask
  always @(posedge clock) begin
    if (optical_integrity_test === 1'b1) begin
      pulse_count = pulse_count + 1;
      reply(selftest_zone);
    end
  end
endmodule

// >>> test/fzv_voting_test.sv
// self-checking bench for the fire zone voting logic
`timescale 1ns/1ps
module fzv_voting_test;
  import fzv_pkg::*;
  logic       clock;
  logic       srst;
  logic       ce;
  logic [5:0] cycle_sw;
  logic       separate_sw;
  logic [2:0] weight_sw;
  logic       nonlatch_sw;
  logic       slave_sw;
  logic       manual_test_sw;
  logic       test_mode;
  logic [7:0] zone_fire;
  logic       selftest_done;
  logic [7:0] selftest_cps;
  logic [7:0] bus_in;
  logic       strobe_in;
  logic       fire_a;
  logic       fire_b;
  logic [7:0] bus_out;
  logic       optical_integrity_test;
  logic [2:0] selftest_zone;
  logic [7:0] selftest_fault;
  logic       fault_led;
  logic       inhibit_led;
  logic [7:0] zone_indicator;
  logic [1:0] voted_output_indicator;
  logic       is_master;
  int         pulse_count;
  int         fail_count;
  int         n_compared;
  int         p0;
  int         toggles;
  ////////////////////////////////////////////////////////////////////////////
  fzv_voting #(.MINUTE_CYCLES(10), .BLINK_CYCLES(4), .STROBE_CYCLES(8)) i_fzv_voting (
    .clock(clock), .srst(srst), .ce(ce), .cycle_sw(cycle_sw),
    .separate_sw(separate_sw), .weight_sw(weight_sw), .nonlatch_sw(nonlatch_sw),
    .slave_sw(slave_sw), .manual_test_sw(manual_test_sw), .test_mode(test_mode),
    .zone_fire(zone_fire), .selftest_done(selftest_done), .selftest_cps(selftest_cps),
    .bus_in(bus_in), .strobe_in(strobe_in), .fire_a(fire_a), .fire_b(fire_b),
    .bus_out(bus_out), .optical_integrity_test(optical_integrity_test),
    .selftest_zone(selftest_zone), .selftest_fault(selftest_fault),
    .fault_led(fault_led), .inhibit_led(inhibit_led),
    .zone_indicator(zone_indicator), .voted_output_indicator(voted_output_indicator),
    .is_master(is_master));
  fzv_partner i_fzv_partner (
    .clock(clock), .optical_integrity_test(optical_integrity_test),
    .selftest_zone(selftest_zone), .selftest_done(selftest_done),
    .selftest_cps(selftest_cps), .pulse_count(pulse_count));
  ////////////////////////////////////////////////////////////////////////////
  always #25 clock = ~clock;
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic config_reset(input logic sep, input logic [2:0] w, input logic nl,
                              input logic sl, input logic man);
    separate_sw  = sep;
    weight_sw    = w;
    nonlatch_sw  = nl;
    slave_sw     = sl;
    manual_test_sw = man;
    zone_fire    = 8'h00;
    test_mode    = 1'b0;
    srst         = 1'b1;
    step(6);
    srst = 1'b0;
    step(2);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    tally_and_finish;
  end
  initial begin
    clock = 1'b0; srst = 1'b1; cycle_sw = 6'h00; bus_in = 8'h00; strobe_in = 1'b0;
    fail_count = 0; n_compared = 0;
    ce = 1'b1;
    // separate, non-latching, B two-of-four, weight bit0 set but ignored
    config_reset(1'b1, 3'h3, 1'b1, 1'b0, 1'b1);
    check(is_master, 1'b1);
    weight_sw = 3'h0;
    zone_fire = 8'h10;
    step(3);
    check({fire_b, fire_a}, 2'h0);
    zone_fire = 8'h31;
    step(3);
    check({fire_b, fire_a}, 2'h3);
    check(fire_a, 1'b1);
    zone_fire = 8'h00;
    step(3);
    check({fire_b, fire_a}, 2'h0);
    // latching, A two-of-four, zones alarm at different times
    config_reset(1'b1, 3'h4, 1'b0, 1'b0, 1'b1);
    zone_fire = 8'h01;
    step(3);
    check(fire_a, 1'b0);
    zone_fire = 8'h02;
    step(3);
    check(fire_a, 1'b1);
    zone_fire = 8'h00;
    step(6);
    check(fire_a, 1'b1);
    // test mode with non-latching switch
    config_reset(1'b1, 3'h0, 1'b1, 1'b0, 1'b1);
    test_mode = 1'b1;
    step(2);
    check({fault_led, inhibit_led}, 2'h3);
    zone_fire = 8'h01;
    step(3);
    check(fire_a, 1'b0);
    check(voted_output_indicator, 2'h1);
    toggles = 0;
    for (int i = 0; i < 16; i++) begin
      step(1);
      if (i > 0 && zone_indicator[0] !== fzv_voting_test.p0[0]) toggles++;
      p0 = zone_indicator[0];
    end
    check(toggles > 2, 1'b1);
    zone_fire = 8'h00;
    step(3);
    check(voted_output_indicator, 2'h1);
    check(zone_indicator, 8'h01);
    test_mode = 1'b0;
    step(3);
    check({fault_led, inhibit_led, voted_output_indicator}, 4'h0);
    check(zone_indicator, 8'h00);
    // common voting slave, need 2+3 zones
    config_reset(1'b0, 3'h5, 1'b1, 1'b1, 1'b1);
    p0 = pulse_count;
    check(is_master, 1'b0);
    zone_fire = 8'h03;
    bus_in    = 8'h03;
    step(4);
    check(fire_b, 1'b0);
    strobe_in = 1'b1;
    step(1);
    strobe_in = 1'b0;
    step(1);
    check(fire_a, 1'b1);
    check(bus_out, 8'h05);
    step(1);
    check(fire_a, 1'b0);
    step(3);
    check(fire_b, 1'b1);
    step(100);
    check(pulse_count - p0, 8'h00);
    // common voting master, need one zone, then a clock-enable freeze
    config_reset(1'b0, 3'h1, 1'b1, 1'b0, 1'b1);
    zone_fire = 8'h01;
    toggles   = 0;
    for (int i = 0; i < 16; i++) begin
      step(1);
      if (fire_a === 1'b1) toggles++;
    end
    check(toggles, 8'h02);
    check(fire_b, 1'b1);
    check(bus_out, 8'h01);
    ce        = 1'b0;
    zone_fire = 8'h03;
    step(4);
    check(bus_out, 8'h01);
    ce = 1'b1;
    step(2);
    check(bus_out, 8'h02);
    // automatic self-test, all cycle switches open
    config_reset(1'b1, 3'h0, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 3000 && selftest_fault[2] !== 1'b1; i++) step(1);
    step(2);
    check(selftest_fault, 8'h04);
    check(selftest_zone, 3'h3);
    check(pulse_count > p0, 1'b1);
    tally_and_finish;
  end
endmodule
